// ==== rtl/edm_cfg.svh ====
// Constants of the extended divide, multiply-accumulate and min/max unit
`ifndef EDM_CFG_SVH
`define EDM_CFG_SVH
`define EDM_OP_NONE     3'h0
`define EDM_OP_DIVS     3'h1
`define EDM_OP_DIVU     3'h2
`define EDM_OP_MACS     3'h3
`define EDM_OP_MAXD     3'h4
`define EDM_OP_MAXM     3'h5
`define EDM_OP_MIND     3'h6
`define EDM_OP_MINM     3'h7
`define EDM_DIV_STEPS   5'h10
`define EDM_FLAG_C      0
`define EDM_FLAG_V      1
`define EDM_FLAG_Z      2
`define EDM_FLAG_N      3
`define EDM_FLAGS_RST   4'h0
`define EDM_ADDR_STATUS 2'h0
`define EDM_ADDR_MASK   2'h1
`define EDM_ADDR_FLAGS  2'h2
`define EDM_EV_DIV0     0
`define EDM_EV_DIVOV    1
`define EDM_EV_MACOV    2
`define EDM_EV_CMPBR    3
`endif

// ==== rtl/edm_pkg.sv ====
// Types of the extended divide, multiply-accumulate and min/max unit
package edm_pkg;
  typedef enum logic [2:0] {
    EDM_IDLE = 3'h0,
    EDM_DIV  = 3'h1,
    EDM_DONE = 3'h3
  } edm_state_type;

  typedef struct packed {
    edm_state_type state;
    logic [2:0]    op;
    logic [4:0]    cnt;
    logic [31:0]   rem;
    logic [15:0]   quo;
    logic [15:0]   dvs;
    logic          neg_q;
    logic          neg_r;
    logic [15:0]   d_out;
    logic [15:0]   y_out;
    logic [31:0]   mem_out;
    logic          wr_d;
    logic          wr_y;
    logic          wr_mem16;
    logic          wr_mem32;
    logic [3:0]    flags;
    logic          done;
    logic [3:0]    status;
    logic [3:0]    mask;
    logic [3:0]    rd_data;
    logic          irq;
    logic          busy;
  } edm_regs_type;
endpackage

// ==== rtl/edm_unit.sv ====
// Extended divide, multiply-accumulate and min/max execution datapath
// Functional notes
// (RULE_01) Signed divide: Y:D over X, quotient to Y, remainder to D.
// (RULE_02) Zero divisor sets C, keeps D and Y; C clear otherwise.
// (RULE_03) Quotient outside signed 16 bits sets V; N, Z from quotient.
// (RULE_04) MAC: signed 16x16 product added to 32-bit memory accumulator.
// (RULE_05) Core fetches MAC operands via X, Y and extended address.
// (RULE_06) MAC V set on signed 32-bit overflow of the sum.
// (RULE_07) MAC C is the carry from bit 15 into bit 16.
// (RULE_08) MAC N from sum bit 31, Z when whole sum zero.
// (RULE_09) Max-to-accumulator leaves larger unsigned value in D.
// (RULE_10) Max-to-memory writes larger value back to memory.
// (RULE_11) Min-to-accumulator leaves smaller unsigned value in D.
// (RULE_12) Min-to-memory writes D to memory when borrow set.
// (RULE_13) Min/max flags come from D minus memory; result discarded.
// (RULE_14) Min/max V from sign bits of D, memory and result; N bit 15.
// (RULE_15) Min/max C is the borrow term on bit 15.
// (RULE_16) Core decodes indexed operand forms of min/max opcodes.
// (RULE_17) Core decodes MAC opcode and extended accumulator address.
// (RULE_18) Unsigned divide by zero sets C and keeps D and Y.
// (RULE_19) Signed quotient truncates to zero; remainder takes dividend sign.
`timescale 1ns/10ps
`include "edm_cfg.svh"
module edm_unit (
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  input  wire logic        start_i,
  input  wire logic [2:0]  op_i,
  input  wire logic [15:0] acc_d_i,
  input  wire logic [15:0] idx_x_i,
  input  wire logic [15:0] idx_y_i,
  input  wire logic [15:0] mem_a_i,
  input  wire logic [15:0] mem_b_i,
  input  wire logic [31:0] mem_acc_i,
  input  wire logic [1:0]  reg_addr_i,
  input  wire logic [3:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [3:0]  reg_rdata_o,
  output logic             irq_o,
  output logic             busy_o,
  output logic             done_o,
  output logic      [15:0] acc_d_o,
  output logic      [15:0] idx_y_o,
  output logic      [31:0] mem_o,
  output logic             wr_d_o,
  output logic             wr_y_o,
  output logic             wr_mem16_o,
  output logic             wr_mem32_o,
  output logic      [3:0]  flags_o
);
  // Register map: 0 status (write one clears), 1 mask, 2 last flags
  localparam logic [1:0] ADDR_STATUS = `EDM_ADDR_STATUS;
  localparam logic [1:0] ADDR_MASK   = `EDM_ADDR_MASK;
  localparam logic [1:0] ADDR_FLAGS  = `EDM_ADDR_FLAGS;

  edm_pkg::edm_regs_type r_reg;
  edm_pkg::edm_regs_type r_next;

  function automatic logic [15:0] neg16(input logic [15:0] v, input logic n);
    neg16 = n ? 16'(~v + 16'h0001) : v;
  endfunction

  logic [31:0] dividend;
  logic [31:0] prod;
  logic [31:0] sum;
  logic [15:0] diff;
  logic        borrow;
  logic [32:0] trial;
  logic [3:0]  ev;
  logic [15:0] qs;
  logic [15:0] rs;
  logic        qov;

  always_comb begin
    dividend = {idx_y_i, acc_d_i};
    prod   = 32'($signed(mem_a_i) * $signed(mem_b_i)); // RULE_04 RULE_05
    sum    = 32'(prod + mem_acc_i);                    // RULE_04 RULE_17
    diff   = 16'(acc_d_i - mem_b_i);                   // RULE_13 RULE_16
    borrow = (~acc_d_i[15] & mem_b_i[15]) | (mem_b_i[15] & diff[15])
           | (diff[15] & ~acc_d_i[15]);                 // RULE_15
    trial  = {r_reg.rem[31:0], 1'b0} - {1'b0, r_reg.dvs, 16'h0000};
    qs     = neg16(r_reg.quo, r_reg.neg_q);             // RULE_19
    rs     = neg16(r_reg.rem[31:16], r_reg.neg_r);      // RULE_19
    // Unsigned magnitude checked before sign fold; -32768 is legal
    if (r_reg.op == `EDM_OP_DIVS)
      qov = r_reg.neg_q ? (r_reg.quo > 16'h8000) : r_reg.quo[15]; // RULE_03
    else
      qov = 1'b0;
  end

  always_comb begin
    r_next = r_reg;
    ev = 4'h0;
    r_next.done = 1'b0;
    r_next.wr_d = 1'b0;
    r_next.wr_y = 1'b0;
    r_next.wr_mem16 = 1'b0;
    r_next.wr_mem32 = 1'b0;
    r_next.rd_data = 4'h0;
    case (r_reg.state)
      edm_pkg::EDM_IDLE: begin
        if (start_i) begin
          r_next.op = op_i;
          case (op_i)
            `EDM_OP_DIVS, `EDM_OP_DIVU: begin
              if (idx_x_i == 16'h0000) begin
                // D and Y untouched on divide by zero
                r_next.flags = 4'h0;
                r_next.flags[`EDM_FLAG_C] = 1'b1;   // RULE_02 RULE_18
                ev[`EDM_EV_DIV0] = 1'b1;
                r_next.done = 1'b1;
              end else begin
                r_next.neg_q = (op_i == `EDM_OP_DIVS) &
                               (idx_y_i[15] ^ idx_x_i[15]);
                r_next.neg_r = (op_i == `EDM_OP_DIVS) & idx_y_i[15];
                r_next.dvs = neg16(idx_x_i,
                  (op_i == `EDM_OP_DIVS) & idx_x_i[15]);     // RULE_01
                // Magnitude only; signs folded back in at the end
                r_next.rem = ((op_i == `EDM_OP_DIVS) & idx_y_i[15]) ?
                  32'(~dividend + 32'h1) : dividend;
                r_next.quo = 16'h0000;
                r_next.cnt = `EDM_DIV_STEPS;
                r_next.state = edm_pkg::EDM_DIV;
              end
            end
            `EDM_OP_MACS: begin
              r_next.mem_out = sum;                     // RULE_04
              r_next.wr_mem32 = 1'b1;
              r_next.flags[`EDM_FLAG_N] = sum[31];      // RULE_08
              r_next.flags[`EDM_FLAG_Z] = (sum == 32'h0); // RULE_08
              r_next.flags[`EDM_FLAG_V] =
                (prod[31] == mem_acc_i[31]) & (sum[31] != prod[31]); // RULE_06
              r_next.flags[`EDM_FLAG_C] = (mem_acc_i[15] & prod[15])
                | (prod[15] & ~sum[15]) | (~sum[15] & mem_acc_i[15]); // RULE_07
              ev[`EDM_EV_MACOV] = r_next.flags[`EDM_FLAG_V];
              r_next.done = 1'b1;
            end
            `EDM_OP_MAXD, `EDM_OP_MAXM, `EDM_OP_MIND, `EDM_OP_MINM: begin
              r_next.flags[`EDM_FLAG_N] = diff[15];     // RULE_14
              r_next.flags[`EDM_FLAG_Z] = (diff == 16'h0); // RULE_13
              r_next.flags[`EDM_FLAG_V] = (acc_d_i[15] ^ mem_b_i[15])
                & (diff[15] ^ acc_d_i[15]);             // RULE_14
              r_next.flags[`EDM_FLAG_C] = borrow;       // RULE_15
              ev[`EDM_EV_CMPBR] = borrow;
              case (op_i)
                `EDM_OP_MAXD: begin
                  r_next.d_out = borrow ? mem_b_i : acc_d_i; // RULE_09
                  r_next.wr_d = 1'b1;
                end
                `EDM_OP_MAXM: begin
                  r_next.mem_out = {16'h0000,
                    borrow ? mem_b_i : acc_d_i};        // RULE_10
                  r_next.wr_mem16 = 1'b1;
                end
                `EDM_OP_MIND: begin
                  r_next.d_out = borrow ? acc_d_i : mem_b_i; // RULE_11
                  r_next.wr_d = 1'b1;
                end
                default: begin
                  r_next.mem_out = {16'h0000,
                    borrow ? acc_d_i : mem_b_i};        // RULE_12
                  r_next.wr_mem16 = 1'b1;
                end
              endcase
              r_next.done = 1'b1;
            end
            default: r_next.done = 1'b1;
          endcase
        end
      end
      edm_pkg::EDM_DIV: begin
        // Restoring divide, one quotient bit a cycle, keeps area small
        if (!trial[32]) begin
          r_next.rem = trial[31:0];
          r_next.quo = {r_reg.quo[14:0], 1'b1};
        end else begin
          r_next.rem = {r_reg.rem[30:0], 1'b0};
          r_next.quo = {r_reg.quo[14:0], 1'b0};
        end
        r_next.cnt = 5'(r_reg.cnt - 5'h01);
        if (r_reg.cnt == 5'h01)
          r_next.state = edm_pkg::EDM_DONE;
      end
      edm_pkg::EDM_DONE: begin
        r_next.flags = 4'h0;
        if (r_reg.op == `EDM_OP_DIVS) begin
          r_next.flags[`EDM_FLAG_V] = qov;             // RULE_03
          r_next.y_out = qs;                            // RULE_01
          r_next.d_out = rs;                            // RULE_01
          r_next.flags[`EDM_FLAG_N] = qs[15];           // RULE_03
          r_next.flags[`EDM_FLAG_Z] = (qs == 16'h0);    // RULE_03
        end else begin
          r_next.y_out = r_reg.quo;
          r_next.d_out = r_reg.rem[31:16];
          r_next.flags[`EDM_FLAG_N] = r_reg.quo[15];
          r_next.flags[`EDM_FLAG_Z] = (r_reg.quo == 16'h0);
        end
        r_next.wr_d = 1'b1;
        r_next.wr_y = 1'b1;
        ev[`EDM_EV_DIVOV] = qov;
        r_next.done = 1'b1;
        r_next.state = edm_pkg::EDM_IDLE;
      end
      default: r_next.state = edm_pkg::EDM_IDLE;
    endcase
    // Set wins over a write-one clear in the same cycle
    if (reg_wr_i && reg_addr_i == ADDR_STATUS)
      r_next.status = r_reg.status & ~reg_wdata_i;
    if (reg_wr_i && reg_addr_i == ADDR_MASK)
      r_next.mask = reg_wdata_i;
    r_next.status = r_next.status | ev;
    if (reg_rd_i) begin
      case (reg_addr_i)
        ADDR_STATUS: r_next.rd_data = r_reg.status;
        ADDR_MASK:   r_next.rd_data = r_reg.mask;
        ADDR_FLAGS:  r_next.rd_data = r_reg.flags;
        default:     r_next.rd_data = 4'h0;
      endcase
    end
    r_next.irq = |(r_next.status & r_next.mask);
    r_next.busy = (r_next.state != edm_pkg::EDM_IDLE);
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      r_reg <= '0;
      r_reg.flags <= `EDM_FLAGS_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign reg_rdata_o = r_reg.rd_data;
  assign irq_o       = r_reg.irq;
  assign busy_o      = r_reg.busy;
  assign done_o      = r_reg.done;
  assign acc_d_o     = r_reg.d_out;
  assign idx_y_o     = r_reg.y_out;
  assign mem_o       = r_reg.mem_out;
  assign wr_d_o      = r_reg.wr_d;
  assign wr_y_o      = r_reg.wr_y;
  assign wr_mem16_o  = r_reg.wr_mem16;
  assign wr_mem32_o  = r_reg.wr_mem32;
  assign flags_o     = r_reg.flags;

  property p_div_zero;
    @(posedge sys_clk_i) disable iff (reset_i)
    (start_i && !busy_o && (op_i == `EDM_OP_DIVS || op_i == `EDM_OP_DIVU)
     && idx_x_i == 16'h0) |=> (flags_o[0] && done_o && !wr_d_o && !wr_y_o);
  endproperty
  a_div_zero: assert property (p_div_zero) // RULE_02
    else $error("divide by zero must set carry and keep registers");

  property p_div_len;
    @(posedge sys_clk_i) disable iff (reset_i)
    (start_i && !busy_o && op_i == `EDM_OP_DIVS && idx_x_i != 16'h0)
    |=> busy_o [*8] ##10 (done_o && wr_y_o && wr_d_o && !flags_o[0]);
  endproperty
  a_div_len: assert property (p_div_len) // RULE_01
    else $error("signed divide must finish after 18 cycles");

  property p_div_math;
    @(posedge sys_clk_i) disable iff (reset_i)
    (r_reg.state == edm_pkg::EDM_DONE && r_reg.op == `EDM_OP_DIVS && !qov)
    |=> (flags_o[3] == idx_y_o[15] && flags_o[2] == (idx_y_o == 16'h0));
  endproperty
  a_div_math: assert property (p_div_math) // RULE_03
    else $error("divide flags disagree with quotient");

  property p_mac;
    @(posedge sys_clk_i) disable iff (reset_i)
    (start_i && !busy_o && op_i == `EDM_OP_MACS) |=>
    (wr_mem32_o && mem_o == 32'($past(prod) + $past(mem_acc_i))
     && flags_o[3] == mem_o[31] && flags_o[2] == (mem_o == 32'h0));
  endproperty
  a_mac: assert property (p_mac) // RULE_08
    else $error("accumulate result or flags wrong");

  property p_mac_ov;
    @(posedge sys_clk_i) disable iff (reset_i)
    (start_i && !busy_o && op_i == `EDM_OP_MACS) |=>
    flags_o[1] == ($past(prod[31]) == $past(mem_acc_i[31])
                   && mem_o[31] != $past(prod[31]));
  endproperty
  a_mac_ov: assert property (p_mac_ov) // RULE_06
    else $error("accumulate overflow flag wrong");

  property p_max_d;
    @(posedge sys_clk_i) disable iff (reset_i)
    (start_i && !busy_o && op_i == `EDM_OP_MAXD) |=>
    (wr_d_o && acc_d_o >= $past(acc_d_i) && acc_d_o >= $past(mem_b_i));
  endproperty
  a_max_d: assert property (p_max_d) // RULE_09
    else $error("maximum to accumulator not the larger value");

  property p_min_m;
    @(posedge sys_clk_i) disable iff (reset_i)
    (start_i && !busy_o && op_i == `EDM_OP_MINM) |=>
    (wr_mem16_o && mem_o[15:0] <= $past(acc_d_i)
     && mem_o[15:0] <= $past(mem_b_i));
  endproperty
  a_min_m: assert property (p_min_m) // RULE_12
    else $error("minimum to memory not the smaller value");

  property p_cmp_c;
    @(posedge sys_clk_i) disable iff (reset_i)
    (start_i && !busy_o && op_i >= `EDM_OP_MAXD) |=>
    (flags_o[0] == ($past(mem_b_i) > $past(acc_d_i))
     && flags_o[2] == ($past(mem_b_i) == $past(acc_d_i)));
  endproperty
  a_cmp_c: assert property (p_cmp_c) // RULE_13
    else $error("compare borrow or equal flag wrong");

  c_div: cover property (@(posedge sys_clk_i) disable iff (reset_i)
    r_reg.state == edm_pkg::EDM_DONE && qov);
  c_mac: cover property (@(posedge sys_clk_i) disable iff (reset_i)
    wr_mem32_o && flags_o[1]);
  c_irq: cover property (@(posedge sys_clk_i) disable iff (reset_i)
    irq_o);
endmodule // edm_unit

// ==== sim/edm_mem_model.sv ====
// Data memory model: operand words and 32-bit accumulator
`timescale 1ns/10ps
module edm_mem_model (
  input  wire logic        sys_clk_i,
  input  wire logic [15:0] aptr_i,
  input  wire logic [15:0] bptr_i,
  input  wire logic [15:0] eptr_i,
  input  wire logic        wr16_i,
  input  wire logic        wr32_i,
  input  wire logic [31:0] wdata_i,
  output logic      [15:0] word_a_o,
  output logic      [15:0] word_b_o,
  output logic      [31:0] acc_o
);
  logic [7:0] mem [0:63];
  logic [5:0] a, b, e;

  assign a = aptr_i[5:0];
  assign b = bptr_i[5:0];
  assign e = eptr_i[5:0];
  // Most significant byte at the lowest address
  assign word_a_o = {mem[a], mem[a + 6'h1]};
  assign word_b_o = {mem[b], mem[b + 6'h1]};
  assign acc_o    = {mem[e], mem[e + 6'h1],
                     mem[e + 6'h2], mem[e + 6'h3]};

  task automatic put(input logic [5:0] p, input logic [31:0] v, input int n);
    for (int i = 0; i < n; i++) mem[p + 6'(i)] = v[8*(n-1-i) +: 8];
  endtask

  initial for (int i = 0; i < 64; i++) mem[i] = 8'h0;

  // Blocking writes: the bench preloads through put as well
  always @(posedge sys_clk_i) begin
    if (wr32_i) put(e, wdata_i, 4);
    if (wr16_i) put(b, wdata_i, 2);
  end
endmodule // edm_mem_model

// ==== sim/edm_unit_bench.sv ====
// Self-checking bench of the divide, MAC and min/max unit
`timescale 1ns/10ps
`include "edm_cfg.svh"
module edm_unit_bench;
  logic        sys_clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        start_i = 1'b0;
  logic [2:0]  op_i = 3'h0;
  logic [15:0] acc_d_i = 16'h0;
  logic [15:0] idx_x_i = 16'h0;
  logic [15:0] idx_y_i = 16'h0;
  logic [1:0]  reg_addr_i = 2'h0;
  logic [3:0]  reg_wdata_i = 4'h0;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic [3:0]  reg_rdata_o, flags_o, f;
  logic        irq_o, busy_o, done_o, wr_d_o, wr_y_o, wr_mem16_o, wr_mem32_o;
  logic [15:0] acc_d_o, idx_y_o, mem_a, mem_b, bptr, d, m, r;
  logic [31:0] mem_o, mem_acc, s, p;
  int          error_cnt = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          lat, q, rm;
  logic [31:0] dv_t [7] = '{32'd100, 32'hffffff9c, 32'd100, 32'hffffff9c,
                            32'hffff8000, 32'h8000, 32'h18000};
  logic [15:0] dx_t [7] = '{16'h7, 16'h7, 16'hfff9, 16'hfff9, 16'h1, 16'h1,
                            16'h2};
  logic [15:0] ma_t [4] = '{16'h3, 16'h1, 16'h1, 16'h2};
  logic [15:0] mb_t [4] = '{16'hfffe, 16'h1, 16'h1, 16'hfffb};
  logic [31:0] mc_t [4] = '{32'ha, 32'h7fffffff, 32'hffff, 32'ha};
  logic [15:0] dd_t [5] = '{16'h5, 16'h9, 16'h7, 16'h8000, 16'h1};
  logic [15:0] mm_t [5] = '{16'h9, 16'h5, 16'h7, 16'h1, 16'h8000};

  // MAC second operand sits at Y; min/max word at a fixed indexed address
  assign bptr = (op_i == `EDM_OP_MACS) ? idx_y_i : 16'h10;

  edm_unit dut (.sys_clk_i, .reset_i, .start_i, .op_i, .acc_d_i, .idx_x_i,
    .idx_y_i, .mem_a_i(mem_a), .mem_b_i(mem_b), .mem_acc_i(mem_acc),
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_o,
    .busy_o, .done_o, .acc_d_o, .idx_y_o, .mem_o, .wr_d_o, .wr_y_o,
    .wr_mem16_o, .wr_mem32_o, .flags_o);

  edm_mem_model ram (.sys_clk_i, .aptr_i(idx_x_i), .bptr_i(bptr),
    .eptr_i(16'h8), .wr16_i(wr_mem16_o), .wr32_i(wr_mem32_o),
    .wdata_i(mem_o), .word_a_o(mem_a), .word_b_o(mem_b), .acc_o(mem_acc));

  initial forever #12.5 sys_clk_i = ~sys_clk_i;

  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Run takes about 300 cycles; the ceiling leaves wide margin
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic chk_val(input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flg(input logic [3:0] got, exp, k);
    total_checks++;
    if ((got & k) !== (exp & k)) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_write(input logic [1:0] a, input logic [3:0] v);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic reg_read(input logic [1:0] a, input logic [3:0] e, k);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge sys_clk_i);
    chk_flg(reg_rdata_o, e, k);
  endtask

  task automatic irq_is(input logic e);
    repeat (2) @(negedge sys_clk_i);
    chk_val(irq_o, e);
  endtask

  // Ends at the negedge where done is seen; lat counts negedges from take
  task automatic run_op(input logic [2:0] op, input logic [15:0] a, x, y);
    @(posedge sys_clk_i);
    op_i <= op;
    acc_d_i <= a;
    idx_x_i <= x;
    idx_y_i <= y;
    start_i <= 1'b1;
    @(posedge sys_clk_i);
    start_i <= 1'b0;
    lat = 0;
    do begin
      @(negedge sys_clk_i);
      lat++;
    end while (done_o !== 1'b1 && lat < 40);
  endtask

  initial begin
    repeat (8) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    @(negedge sys_clk_i);
    chk_flg(flags_o, 4'h0, 4'hf);
    for (int i = 0; i < 4; i++) reg_read(2'(i), 4'h0, 4'hf);
    $display("test reset done");
    foreach (dv_t[i]) begin
      run_op(`EDM_OP_DIVS, dv_t[i][15:0], dx_t[i], dv_t[i][31:16]);
      q = $signed(dv_t[i]) / int'($signed(dx_t[i]));
      rm = $signed(dv_t[i]) % int'($signed(dx_t[i]));
      chk_val(32'(lat), 32'd18);
      chk_val(busy_o, 1'b0);
      if (q > 32767 || q < -32768)
        chk_flg(flags_o, 4'h2, 4'h3);
      else begin
        chk_flg(flags_o, {q[15], q[15:0] == 16'h0, 2'b00}, 4'hf);
        chk_val(idx_y_o, q[15:0]);
        chk_val(acc_d_o, rm[15:0]);
      end
    end
    run_op(`EDM_OP_DIVU, 16'h0001, 16'hffff, 16'hfffe);
    chk_val(32'(lat), 32'd18);
    chk_flg(flags_o, 4'h8, 4'hd);
    chk_val(idx_y_o, 16'hffff);
    chk_val(acc_d_o, 16'h0000);
    reg_read(2'h0, 4'h2, 4'hf);
    reg_write(2'h0, 4'hf);
    $display("test signed divide done");
    reg_write(2'h1, 4'h1);
    for (int i = 1; i < 3; i++) begin
      run_op(3'(i), 16'h1234, 16'h0, 16'h5678);
      chk_val(32'(lat), 32'd1);
      chk_flg(flags_o, 4'h1, 4'h1);
      chk_val(wr_d_o, 1'b0);
      chk_val(wr_y_o, 1'b0);
      irq_is(1'b1);
      reg_read(2'h0, 4'h1, 4'hf);
      reg_write(2'h1, 4'h0);
      irq_is(1'b0);
      reg_write(2'h1, 4'h1);
      irq_is(1'b1);
      reg_write(2'h0, 4'h1);
      irq_is(1'b0);
    end
    reg_write(2'h2, 4'he);
    reg_read(2'h2, 4'h1, 4'h1);
    $display("test divide by zero done");
    foreach (mc_t[i]) begin
      ram.put(6'h0, {16'h0, ma_t[i]}, 2);
      ram.put(6'h2, {16'h0, mb_t[i]}, 2);
      ram.put(6'h8, mc_t[i], 4);
      run_op(`EDM_OP_MACS, 16'h0, 16'h0, 16'h2);
      p = int'($signed(ma_t[i])) * int'($signed(mb_t[i]));
      s = mc_t[i] + p;
      f = {s[31], s == 32'h0, mc_t[i][31] == p[31] && s[31] != p[31],
           mc_t[i][15] & p[15] | p[15] & ~s[15] | ~s[15] & mc_t[i][15]};
      chk_val(mem_o, s);
      chk_flg(flags_o, f, 4'hf);
      chk_flg({wr_d_o, wr_y_o, wr_mem16_o, wr_mem32_o}, 4'h1, 4'hf);
      @(negedge sys_clk_i);
      chk_val(mem_acc, s);
    end
    reg_read(2'h0, 4'h4, 4'hf);
    reg_write(2'h0, 4'hf);
    $display("test multiply accumulate done");
    foreach (dd_t[i]) for (int o = 4; o < 8; o++) begin
      ram.put(6'h10, {16'h0, mm_t[i]}, 2);
      run_op(3'(o), dd_t[i], 16'h0, 16'h0);
      d = dd_t[i];
      m = mm_t[i];
      r = d - m;
      f = {r[15], r == 16'h0, d[15] & ~m[15] & ~r[15] | ~d[15] & m[15] & r[15],
           ~d[15] & m[15] | m[15] & r[15] | r[15] & ~d[15]};
      chk_flg(flags_o, f, 4'hf);
      r = ((o < 6) == f[0]) ? m : d;
      chk_flg({wr_d_o, wr_y_o, wr_mem16_o, wr_mem32_o}, (o % 2) ? 4'h2 : 4'h8,
              4'hf);
      if (o % 2 == 0)
        chk_val(acc_d_o, r);
      else begin
        chk_val(mem_o[15:0], r);
        @(negedge sys_clk_i);
        chk_val(mem_b, r);
      end
    end
    reg_read(2'h0, 4'h8, 4'hf);
    reg_write(2'h1, 4'h8);
    irq_is(1'b1);
    reg_write(2'h0, 4'h8);
    irq_is(1'b0);
    $display("test min max done");
    give_verdict();
  end
endmodule // edm_unit_bench
